// *** rtl/twt_core.sv ***
// Purpose: Trigger window delay, extended timestamp and event framing with INL correction
// Assumes: APB slave; hits and triggers synchronous to i_clk
// Notes:   Module time base is a 40 MHz enable from a divider
// What this block does
// - Window width and offset are 12-bit values counted in 25 ns cycles.
// - Straddling or later windows get a 40-cycle internal trigger delay.
// - Per-channel time counter wraps at 2^19, or 2^17 at coarsest resolution.
// - Free 32-bit counter captured on each trigger, reported when enabled.
// - Timestamp word has id 10001 on top, counter bits 31..5 below.
// - With timestamp on, trailer carries counter low five bits instead of slot.
// - Timestamp reporting off at reset, on when control bits 9 and 11 set.
// - Events without hits inside the window can optionally be suppressed.
// - Correction subtracts table entry chosen by code position within clock period.
// - Medium resolution uses 128 entries indexed by code masked with 0x7f.
// - Finest resolution uses 256 entries indexed by code masked with 0xff.
// - Coarsest 800 ps resolution passes codes unchanged.
// - Correction on by default, cleared control bit 5 disables it.
// - Correction table is loaded from on-board flash storage.
// - Each event's hits lie between header and trailer; trailer repeats event id.
module twt_core #(
  parameter int                CODE_W    = twt_pkg::CODE_W,
  parameter logic [4:0]        SLOT_ADDR = 5'h00
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [15:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Flash table loader
  input  wire logic              i_flash_we,
  input  wire logic [7:0]        i_flash_addr,
  input  wire logic [7:0]        i_flash_data,
  // Trigger and hits
  input  wire logic              i_trigger,
  input  wire logic              i_hit_valid,
  input  wire logic [CODE_W-1:0] i_hit_code,
  input  wire logic              i_hit_in_window,
  input  wire logic              i_window_done,
  // Event word stream
  output logic                   o_word_valid,
  output logic [31:0]            o_word,
  output logic                   o_match_trigger,
  output logic                   o_cfg_error
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum {
    ST_IDLE,
    ST_HEADER,
    ST_BODY,
    ST_STAMP,
    ST_TRAILER
  } twt_ev_type;

  typedef struct packed {
    logic [15:0]       ctl;
    logic [11:0]       width;
    logic [11:0]       offset_mag;
    logic              offset_neg;
    logic [2:0]        div;
    logic [31:0]       extended_trigger_timestamp;
    logic [31:0]       extended_trigger_timestamp_lat;
    logic [5:0]        dly_cnt;
    logic              dly_busy;
    logic [18:0]       chan_cnt;
    logic [11:0]       event_id;
    logic [11:0]       hit_count;
    logic              held;
    logic [CODE_W-1:0] held_code;
    twt_ev_type        ev;
    logic              word_valid;
    logic [31:0]       word;
    logic              match;
    logic [31:0]       prdata;
  } twt_state_type;

  twt_state_type s_q, s_d;

  logic              corr_valid;
  logic [CODE_W-1:0] corr_code;
  logic              tick;
  logic              extended_trigger_timestamp_on;
  logic              wr_en;
  logic              rd_en;
  logic              lut_hit;
  logic              addr_ok;
  logic [1:0]        res;
  logic              straddle;
  logic [12:0]       sum_win;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] twt_frame(input logic [4:0] tag, input logic [26:0] body);
    twt_frame = {tag, body};
  endfunction

  function automatic logic [31:0] twt_head(input logic [11:0] id);
    twt_head = twt_frame(twt_pkg::TAG_HEADER, {10'h000, id, SLOT_ADDR});
  endfunction

  function automatic logic [18:0] twt_wrap(input logic [18:0] cnt, input logic [1:0] r);
    logic [18:0] nxt;
    nxt = cnt + 19'h00001;
    if (r == twt_pkg::TWT_RES_800PS) begin
      nxt[18:twt_pkg::WRAP_COARSE] = '0;
    end
    twt_wrap = nxt;
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign res      = s_q.ctl[twt_pkg::CTL_RES_LSB +: 2];
  assign straddle = s_q.ctl[twt_pkg::CTL_STRADDLE_BIT];
  assign extended_trigger_timestamp_on  = (s_q.ctl & twt_pkg::CTL_EXTENDED_TRIGGER_TIMESTAMP_MASK) == twt_pkg::CTL_EXTENDED_TRIGGER_TIMESTAMP_MASK;
  assign tick     = (s_q.div == 3'(twt_pkg::MOD_DIV - 1));
  assign wr_en    = i_psel && i_penable && i_pwrite;
  assign rd_en    = i_psel && !i_penable && !i_pwrite;
  assign lut_hit  = (i_paddr & twt_pkg::ADDR_LUT_MASK) == twt_pkg::ADDR_LUT_BASE;
  assign addr_ok  = lut_hit || i_paddr == twt_pkg::ADDR_CONTROL || i_paddr == twt_pkg::ADDR_WINDOW
                 || i_paddr == twt_pkg::ADDR_STATUS || i_paddr == twt_pkg::ADDR_COUNTER
                 || i_paddr == twt_pkg::ADDR_LATCHED;
  assign sum_win  = s_q.offset_neg ? 13'(s_q.width) - 13'(s_q.offset_mag)
                                   : 13'(s_q.width) + 13'(s_q.offset_mag);
  // Settings legality check
  assign o_cfg_error = straddle ? (!s_q.offset_neg ? (sum_win > 13'(twt_pkg::TRIG_DELAY_CYC))
                                 : ($signed(sum_win) > $signed(13'(twt_pkg::TRIG_DELAY_CYC))))
                                : (!s_q.offset_neg || s_q.width >= s_q.offset_mag);

  // ------------------------------------------------------------
  // INL correction
  // ------------------------------------------------------------
  twt_inl_corr #(
    .CODE_W (CODE_W),
    .DEPTH  (twt_pkg::LUT_DEPTH)
  ) u_inl (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_lut_we   (i_flash_we || (wr_en && lut_hit)),
    .i_lut_addr (i_flash_we ? i_flash_addr : i_paddr[9:2]),
    .i_lut_data (i_flash_we ? i_flash_data : i_pwdata[7:0]),
    .i_enable   (s_q.ctl[twt_pkg::CTL_INL_EN_BIT]),
    .i_res      (res),
    .i_valid    (i_hit_valid),
    .i_code     (i_hit_code),
    .o_valid    (corr_valid),
    .o_code     (corr_code)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.word_valid = 1'b0;
    s_d.match      = 1'b0;
    s_d.div        = tick ? 3'h0 : s_q.div + 3'h1;
    if (tick) begin
      s_d.extended_trigger_timestamp     = s_q.extended_trigger_timestamp + 32'h00000001;
      s_d.chan_cnt = twt_wrap(s_q.chan_cnt, res);
    end
    if (wr_en) begin
      case (i_paddr)
        twt_pkg::ADDR_CONTROL: begin
          s_d.ctl = i_pwdata[15:0];
        end
        twt_pkg::ADDR_WINDOW: begin
          s_d.width      = i_pwdata[11:0];
          s_d.offset_mag = i_pwdata[27:16];
          s_d.offset_neg = i_pwdata[31];
        end
        default: begin
        end
      endcase
    end
    if (rd_en) begin
      case (i_paddr)
        twt_pkg::ADDR_CONTROL: s_d.prdata = {16'h0000, s_q.ctl};
        twt_pkg::ADDR_WINDOW:  s_d.prdata = {s_q.offset_neg, 3'h0, s_q.offset_mag, 4'h0, s_q.width};
        twt_pkg::ADDR_STATUS:  s_d.prdata = {o_cfg_error, s_q.dly_busy, 10'h000, s_q.event_id, 8'h00};
        twt_pkg::ADDR_COUNTER: s_d.prdata = s_q.extended_trigger_timestamp;
        twt_pkg::ADDR_LATCHED: s_d.prdata = s_q.extended_trigger_timestamp_lat;
        default:               s_d.prdata = 32'h00000000;
      endcase
    end
    // Trigger capture and optional delay
    if (i_trigger) begin
      s_d.extended_trigger_timestamp_lat = s_q.extended_trigger_timestamp;
      if (straddle) begin
        s_d.dly_busy = 1'b1;
        s_d.dly_cnt  = 6'h00;
      end else begin
        s_d.match = 1'b1;
      end
    end else if (s_q.dly_busy && tick) begin
      if (s_q.dly_cnt == 6'(twt_pkg::TRIG_DELAY_CYC - 1)) begin
        s_d.dly_busy = 1'b0;
        s_d.match    = 1'b1;
      end else begin
        s_d.dly_cnt = s_q.dly_cnt + 6'h01;
      end
    end
    // Event framing
    case (s_q.ev)
      ST_IDLE: begin
        if (s_q.match) begin
          s_d.ev        = ST_HEADER;
          s_d.hit_count = 12'h000;
          s_d.held      = 1'b0;
        end
      end
      ST_HEADER: begin
        s_d.ev = ST_BODY;
        if (!s_q.ctl[twt_pkg::CTL_SUPPR_BIT]) begin
          s_d.word_valid = 1'b1;
          s_d.word       = twt_head(s_q.event_id);
        end
      end
      ST_BODY: begin
        s_d.held = 1'b0;
        // Drain a hit held behind a late header
        if (s_q.held) begin
          s_d.word_valid = 1'b1;
          s_d.word       = twt_frame(twt_pkg::TAG_DATUM, 27'(s_q.held_code));
        end
        if (corr_valid && i_hit_in_window) begin
          s_d.hit_count = s_q.hit_count + 12'h001;
          if (!s_q.ctl[twt_pkg::CTL_SUPPR_BIT]) begin
            s_d.word_valid = 1'b1;
            s_d.word       = twt_frame(twt_pkg::TAG_DATUM, 27'(corr_code));
          end else begin
            // Late header, so hits trail it by one cycle
            s_d.held      = 1'b1;
            s_d.held_code = corr_code;
            if (s_q.hit_count == 12'h000) begin
              s_d.word_valid = 1'b1;
              s_d.word       = twt_head(s_q.event_id);
            end
          end
        end else if (i_window_done) begin
          s_d.ev = extended_trigger_timestamp_on ? ST_STAMP : ST_TRAILER;
        end
      end
      ST_STAMP: begin
        s_d.ev = ST_TRAILER;
        if (!(s_q.ctl[twt_pkg::CTL_SUPPR_BIT] && s_q.hit_count == 12'h000)) begin
          s_d.word_valid = 1'b1;
          s_d.word       = {twt_pkg::EXTENDED_TRIGGER_TIMESTAMP_ID, s_q.extended_trigger_timestamp_lat[31:5]};
        end
      end
      ST_TRAILER: begin
        s_d.ev       = ST_IDLE;
        s_d.event_id = s_q.event_id + 12'h001;
        if (!(s_q.ctl[twt_pkg::CTL_SUPPR_BIT] && s_q.hit_count == 12'h000)) begin
          s_d.word_valid = 1'b1;
          s_d.word = twt_frame(twt_pkg::TAG_TRAILER, {s_q.event_id, s_q.hit_count[9:0],
                     extended_trigger_timestamp_on ? s_q.extended_trigger_timestamp_lat[4:0] : SLOT_ADDR});
        end
      end
      default: s_d.ev = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q     <= '0;
      s_q.ctl <= twt_pkg::CTL_RESET;
      s_q.ev  <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_prdata        = s_q.prdata;
  assign o_pready        = 1'b1;
  assign o_pslverr       = i_psel && i_penable && !addr_ok;
  assign o_word_valid    = s_q.word_valid;
  assign o_word          = s_q.word;
  assign o_match_trigger = s_q.match;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_extended_trigger_timestamp_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_trigger |=> s_q.extended_trigger_timestamp_lat == $past(s_q.extended_trigger_timestamp))
    else $error("timestamp not captured");
  chk_extended_trigger_timestamp_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tick && s_q.extended_trigger_timestamp == 32'hffffffff) |=> s_q.extended_trigger_timestamp == 32'h00000000)
    else $error("timestamp wrap wrong");
  chk_stamp_id: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_STAMP && s_d.word_valid) |=> o_word[31:27] == twt_pkg::EXTENDED_TRIGGER_TIMESTAMP_ID)
    else $error("stamp word id wrong");
  chk_trailer_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_TRAILER && s_d.word_valid && extended_trigger_timestamp_on) |=> o_word[4:0] == $past(s_q.extended_trigger_timestamp_lat[4:0]))
    else $error("trailer low bits wrong");
  chk_no_stamp_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_BODY && !extended_trigger_timestamp_on) |=> s_q.ev != ST_STAMP)
    else $error("stamp sent while disabled");
  chk_chan_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tick && res == twt_pkg::TWT_RES_800PS) |=> s_q.chan_cnt[18:17] == 2'b00)
    else $error("channel counter wrap wrong");
  chk_chan_roll: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tick && res != twt_pkg::TWT_RES_800PS && s_q.chan_cnt == 19'h7ffff) |=> s_q.chan_cnt == 19'h00000)
    else $error("channel counter roll wrong");
  chk_delay_match: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_trigger && straddle) |=> !s_q.match)
    else $error("delayed trigger matched early");
  chk_suppress: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_TRAILER && s_q.ctl[twt_pkg::CTL_SUPPR_BIT] && s_q.hit_count == 12'h000) |=> !o_word_valid)
    else $error("empty event not suppressed");
  chk_header_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_IDLE && s_q.match) |=> s_q.ev == ST_HEADER)
    else $error("event not opened by header");
  chk_late_header: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_BODY && s_q.ctl[twt_pkg::CTL_SUPPR_BIT] && corr_valid && i_hit_in_window
     && s_q.hit_count == 12'h000) |=> (o_word_valid && o_word[31:27] == twt_pkg::TAG_HEADER))
    else $error("late header missing");
  chk_held_datum: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_BODY && s_q.held) |=> (o_word_valid && o_word[31:27] == twt_pkg::TAG_DATUM))
    else $error("held hit not sent");
  chk_delay_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.dly_busy && tick && !i_trigger && s_q.dly_cnt == 6'(twt_pkg::TRIG_DELAY_CYC - 1)) |=> s_q.match)
    else $error("delayed trigger never matched");
  chk_event_id: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (s_q.ev == ST_TRAILER) |=> s_q.event_id == $past(s_q.event_id) + 12'h001)
    else $error("event id not advanced");
endmodule

// *** rtl/twt_pkg.sv ***
// Purpose: Shared constants for the trigger window / timestamp / INL block
// Assumes: APB slave, 32-bit data, 200 MHz system clock
// Notes:   Offsets are byte addresses
package twt_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [15:0] ADDR_CONTROL  = 16'h1000;
  localparam logic [15:0] ADDR_WINDOW   = 16'h1004;
  localparam logic [15:0] ADDR_STATUS   = 16'h1008;
  localparam logic [15:0] ADDR_COUNTER  = 16'h100c;
  localparam logic [15:0] ADDR_LATCHED  = 16'h1010;
  localparam logic [15:0] ADDR_LUT_BASE = 16'h1400;
  localparam logic [15:0] ADDR_LUT_MASK = 16'hfc00;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  localparam int          CTL_W           = 16;
  localparam logic [15:0] CTL_RESET       = 16'h0020;
  localparam logic [15:0] CTL_EXTENDED_TRIGGER_TIMESTAMP_MASK   = 16'h0a00;
  localparam int          CTL_INL_EN_BIT  = 5;
  localparam int          CTL_SUPPR_BIT   = 2;
  localparam int          CTL_RES_LSB     = 0;
  localparam int          CTL_STRADDLE_BIT = 3;

  // ------------------------------------------------------------
  // Window, timing, words
  // ------------------------------------------------------------
  localparam int          WIN_W          = 12;
  localparam logic [11:0] WIN_MAX        = 12'hfff;
  localparam int          TRIG_DELAY_CYC = 40;
  localparam int          CLK_HZ         = 200_000_000;
  localparam int          MOD_CLK_HZ     = 40_000_000;
  localparam int          MOD_DIV        = CLK_HZ / MOD_CLK_HZ;
  localparam logic [4:0]  EXTENDED_TRIGGER_TIMESTAMP_ID        = 5'h11;
  localparam int          SLOT_W         = 5;
  localparam int          CODE_W         = 21;
  localparam int          WRAP_FINE      = 19;
  localparam int          WRAP_COARSE    = 17;
  localparam int          LUT_DEPTH      = 256;
  localparam logic [7:0]  MASK_MED       = 8'h7f;
  localparam logic [7:0]  MASK_FINE      = 8'hff;

  // Resolution select
  typedef enum logic [1:0] {
    TWT_RES_800PS,
    TWT_RES_200PS,
    TWT_RES_100PS,
    TWT_RES_SPARE
  } twt_res_type;

  // Event word tags (top bits)
  localparam logic [4:0]  TAG_HEADER  = 5'h08;
  localparam logic [4:0]  TAG_TRAILER = 5'h10;
  localparam logic [4:0]  TAG_DATUM   = 5'h00;
endpackage

// *** rtl/twt_inl_corr.sv ***
// Purpose: INL correction of fine-time codes by lookup table
// Assumes: Table loaded word by word from flash loader or bus
// Notes:   One cycle latency, data output registered
module twt_inl_corr #(
  parameter int CODE_W = 21,
  parameter int DEPTH  = 256
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // Table load
  input  wire logic              i_lut_we,
  input  wire logic [7:0]        i_lut_addr,
  input  wire logic [7:0]        i_lut_data,
  // Controls
  input  wire logic              i_enable,
  input  wire logic [1:0]        i_res,
  // Code stream
  input  wire logic              i_valid,
  input  wire logic [CODE_W-1:0] i_code,
  output logic                   o_valid,
  output logic [CODE_W-1:0]      o_code
);
  // ------------------------------------------------------------
  // Table and state
  // ------------------------------------------------------------
  logic signed [7:0] lut_mem [DEPTH];

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } twt_inl_state_type;

  twt_inl_state_type s_q, s_d;
  logic [7:0]        idx;
  logic signed [7:0] corr;

  always_ff @(posedge i_clk) begin
    if (i_lut_we) begin
      lut_mem[i_lut_addr] <= i_lut_data;
    end
  end

  always_comb begin
    idx  = (i_res == twt_pkg::TWT_RES_100PS) ? (i_code[7:0] & twt_pkg::MASK_FINE)
                                             : (i_code[7:0] & twt_pkg::MASK_MED);
    corr = lut_mem[idx];
    s_d  = s_q;
    s_d.valid = i_valid;
    if (i_valid) begin
      if (i_enable && (i_res == twt_pkg::TWT_RES_200PS || i_res == twt_pkg::TWT_RES_100PS)) begin
        s_d.code = i_code - CODE_W'(signed'({{(CODE_W-8){corr[7]}}, corr}));
      end else begin
        s_d.code = i_code;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_valid = s_q.valid;
  assign o_code  = s_q.code;

  chk_bypass_coarse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_valid && i_res == twt_pkg::TWT_RES_800PS) |=> (o_valid && o_code == $past(i_code)))
    else $error("coarse code altered");
  chk_bypass_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_valid && !i_enable) |=> (o_code == $past(i_code)))
    else $error("disabled correction altered code");
endmodule

// *** testbench/twt_src.sv ***
// Purpose: Trigger and hit source standing in front of the block
// Assumes: Changes its outputs just after rising edges of i_clk
// Notes:   One event per go pulse; released code lines show inverted data
module twt_src (
  // Clock and commands
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [3:0]  i_nhits,
  input  wire logic        i_in_win,
  input  wire logic [20:0] i_code_base,
  input  wire logic        i_match,
  // Toward the block
  output logic             o_trigger,
  output logic             o_hit_valid,
  output logic [20:0]      o_hit_code,
  output logic             o_in_window,
  output logic             o_window_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Event sequence
  // ------------------------------------------------------------
  initial begin
    o_trigger     = 1'b0;
    o_hit_valid   = 1'b0;
    o_hit_code    = 21'h0;
    o_in_window   = 1'b0;
    o_window_done = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go === 1'b1) begin
        o_trigger <= 1'b1;
        @(posedge i_clk);
        o_trigger <= 1'b0;
        for (int n = 0; n < 400 && i_match !== 1'b1; n++) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
        o_in_window <= i_in_win;
        for (int k = 0; k < i_nhits; k++) begin
          o_hit_valid <= 1'b1;
          o_hit_code  <= i_code_base + 21'(k * 37);
          @(posedge i_clk);
          o_hit_valid <= 1'b0;
          o_hit_code  <= ~o_hit_code;
          @(posedge i_clk);
        end
        repeat (2) @(posedge i_clk);
        o_window_done <= 1'b1;
        @(posedge i_clk);
        o_window_done <= 1'b0;
        o_in_window   <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for twt_core
// Assumes: twt_src drives triggers and hits
// Notes:   Codes and table data come from a bench LFSR
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, cnt0, st, tr, seed = 32'h24;
  logic        prdy, perr, er, et, fwe = 1'b0, go = 1'b0, inw = 1'b0;
  logic [7:0]  faddr = 8'h0, fdata = 8'h0;
  logic [3:0]  nh = 4'h0;
  logic [20:0] cbase = 21'h0, hcode;
  logic        trig, hv, hin, wdone, wv, mt, cerr;
  logic [31:0] w;
  logic [15:0] ctl_m = twt_pkg::CTL_RESET, tcnt = 16'h0, mlat = 16'h0;
  logic [7:0]  lut_m [256];
  logic [31:0] words [$];
  logic [20:0] expd  [$];
  int          err_count = 0, checks = 0, n, k;
  twt_core #(.SLOT_ADDR(5'h15)) dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy),
    .o_pslverr(perr), .i_flash_we(fwe), .i_flash_addr(faddr), .i_flash_data(fdata), .i_trigger(trig),
    .i_hit_valid(hv), .i_hit_code(hcode), .i_hit_in_window(hin), .i_window_done(wdone),
    .o_word_valid(wv), .o_word(w), .o_match_trigger(mt), .o_cfg_error(cerr));
  twt_src src (.i_clk(clk), .i_go(go), .i_nhits(nh), .i_in_win(inw), .i_code_base(cbase), .i_match(mt),
    .o_trigger(trig), .o_hit_valid(hv), .o_hit_code(hcode), .o_in_window(hin), .o_window_done(wdone));
  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [20:0] exp_code(input logic [20:0] c);
    logic [7:0] ix;
    ix = (ctl_m[1:0] == 2'd1) ? (c[7:0] & 8'h7f) : c[7:0];
    if (ctl_m[5] !== 1'b1 || !(ctl_m[1:0] inside {2'd1, 2'd2})) return c;
    return c - {{13{lut_m[ix][7]}}, lut_m[ix]};
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (i == 50) begin
      chk(1'b0, "no pready");
      complete_run();
    end
  endtask
  // Word and expected-code capture, trigger to match latency
  always @(posedge clk) begin
    if (wv === 1'b1) words.push_back(w);
    if (hv === 1'b1 && hin === 1'b1) expd.push_back(exp_code(hcode));
    tcnt <= (trig === 1'b1) ? 16'h0 : tcnt + 16'h1;
    if (mt === 1'b1) mlat <= tcnt;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] cctl [8] = '{16'h20, 16'h20, 16'h20, 16'h20, 16'h28, 16'h28, 16'h28, 16'h28};
    logic [31:0] cwin [8] = '{32'h80650064, 32'h80640064, 32'h8fff000a, 32'h00050064,
                              32'h000a001e, 32'h000b001e, 32'h8005001e, 32'h80050064};
    logic        cexp [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [15:0] ctls [8] = '{16'h0020, 16'h0221, 16'h0a22, 16'h0a02, 16'h0a25, 16'h0a21, 16'h0a2a, 16'h0a26};
    int          nhs  [8] = '{3, 3, 4, 2, 3, 0, 2, 3};
    logic        iws  [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, twt_pkg::ADDR_CONTROL, 32'h0, rd, er);
    chk(rd === 32'h00000020, "control reset value");
    apb(1'b0, 16'h1020, 32'h0, rd, er);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, twt_pkg::ADDR_WINDOW, 32'hffffffff, rd, er);
    apb(1'b0, twt_pkg::ADDR_WINDOW, 32'h0, rd, er);
    chk(rd === 32'h8fff0fff, "window field widths");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, twt_pkg::ADDR_CONTROL, {16'h0, cctl[i]}, rd, er);
      apb(1'b1, twt_pkg::ADDR_WINDOW, cwin[i], rd, er);
      repeat (2) @(posedge clk);
      chk(cerr === cexp[i], "window legality");
      apb(1'b0, twt_pkg::ADDR_STATUS, 32'h0, rd, er);
      chk(rd[31] === cexp[i], "status error bit");
    end
    $display("register tests done");
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      fwe   <= 1'b1;
      faddr <= 8'(i);
      fdata <= seed[7:0];
      lut_m[i] = seed[7:0];
      @(posedge clk);
    end
    fwe <= 1'b0;
    apb(1'b1, twt_pkg::ADDR_LUT_BASE + 16'h03fc, 32'h000000f3, rd, er);
    lut_m[255] = 8'hf3;
    for (int e = 0; e < 8; e++) begin
      ctl_m = ctls[e];
      apb(1'b1, twt_pkg::ADDR_WINDOW, ctls[e][3] ? 32'h0005001e : 32'h80650064, rd, er);
      apb(1'b1, twt_pkg::ADDR_CONTROL, {16'h0, ctls[e]}, rd, er);
      apb(1'b0, twt_pkg::ADDR_COUNTER, 32'h0, cnt0, er);
      seed = lfsr(seed);
      cbase <= seed[20:0];
      nh    <= 4'(nhs[e]);
      inw   <= iws[e];
      go    <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 1000 && wdone !== 1'b1; n++) @(posedge clk);
      if (n == 1000) begin
        chk(1'b0, "window never closed");
        complete_run();
      end
      repeat (10) @(posedge clk);
      et = (ctls[e] & 16'h0a00) == 16'h0a00;
      k = iws[e] ? nhs[e] : 0;
      if (ctls[e][2] && k == 0)
        chk(words.size() == 0, "empty event kept");
      else begin
        chk(words.size() == k + 2 + et, "event word count");
        if (words.size() == k + 2 + et) begin
          chk(words[0][31:27] === twt_pkg::TAG_HEADER, "header tag");
          for (int j = 0; j < k; j++)
            chk(words[1+j][31:27] === twt_pkg::TAG_DATUM && words[1+j][20:0] === expd[j], "datum code");
          tr = words[k+1+et];
          chk(tr[31:27] === twt_pkg::TAG_TRAILER, "trailer tag");
          if (et) begin
            st = words[k+1];
            apb(1'b0, twt_pkg::ADDR_LATCHED, 32'h0, rd, er);
            chk(st[31:27] === twt_pkg::EXTENDED_TRIGGER_TIMESTAMP_ID && st[26:0] === rd[31:5], "stamp word");
            chk(tr[4:0] === rd[4:0], "trailer low bits");
            chk(((st & 32'h07ffffff) * 32 + (tr & 32'h1f)) === rd, "stamp rebuild");
            chk(rd - cnt0 < 32'd64, "stamp capture");
          end else
            chk(tr[4:0] === 5'h15, "trailer slot address");
          chk(ctls[e][3] ? (mlat >= 16'd195 && mlat <= 16'd205) : (mlat === 16'h0), "trigger delay");
        end
      end
      $display("event %0d done", e);
      words.delete();
      expd.delete();
    end
    complete_run();
  end
endmodule
